// >>> dv/adc_ctrl_monitor.sv
// Port-level checker for the converter status and mode register block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_rdata,
  input wire logic [1:0] conv_done,
  input wire logic [1:0] ext_ref_selected,
  input wire logic       primary_converter_on,
  input wire logic       aux_converter_on,
  input wire logic [2:0] op_select,
  input wire logic       converters_reset,
  input wire logic [1:0] result_write_allow,
  input wire logic [1:0] force_full_scale
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic mode_wr;
  assign mode_wr = sfr_wr && (sfr_addr == adc_ctrl_pkg::MODE_ADDR);
  // ************************************************
  // Assertions
  // ************************************************
  reset_pulse_a:
    assert property (converters_reset == $past(mode_wr)) else $error("reset pulse wrong");
  pri_enable_a:
    assert property (mode_wr |=> primary_converter_on == $past(sfr_wdata[5]))
      else $error("primary enable wrong");
  aux_enable_a:
    assert property (mode_wr |=> aux_converter_on == $past(sfr_wdata[4]))
      else $error("aux enable wrong");
  mode_field_a:
    assert property (mode_wr |=> op_select == $past(sfr_wdata[2:0])) else $error("mode field wrong");
  enable_hold_a:
    assert property (!mode_wr |=> $stable({primary_converter_on, aux_converter_on}))
      else $error("enable changed without write");
  single_return_a:
    assert property (op_select == adc_ctrl_pkg::OP_SINGLE && primary_converter_on
      && !aux_converter_on && conv_done[0] && !mode_wr |=> op_select == adc_ctrl_pkg::OP_POWER_DOWN)
      else $error("single mode did not return");
  continuous_stay_a:
    assert property (op_select == adc_ctrl_pkg::OP_CONTINUOUS && !mode_wr
      |=> op_select == adc_ctrl_pkg::OP_CONTINUOUS) else $error("continuous mode left");
  ready_inhibit_a:
    assert property (!mode_wr && conv_done != 2'b00
      |=> (result_write_allow & $past(conv_done)) == 2'b00) else $error("ready not set");
  mode_clear_a:
    assert property (mode_wr && conv_done == 2'b00 |=> result_write_allow == 2'b11)
      else $error("ready not cleared");
  force_ext_a:
    assert property ((force_full_scale & ~ext_ref_selected) == 2'b00) else $error("force wrong");
  stat_reserved_a:
    assert property (sfr_addr == adc_ctrl_pkg::STAT_ADDR |=> sfr_rdata[1:0] == 2'b00)
      else $error("status reserved set");
  unmapped_zero_a:
    assert property (sfr_addr != adc_ctrl_pkg::MODE_ADDR && sfr_addr != adc_ctrl_pkg::STAT_ADDR
      |=> sfr_rdata == 8'h00) else $error("unmapped read nonzero");
  single_c: cover property (op_select == adc_ctrl_pkg::OP_SINGLE ##1 op_select == 3'h0);
  cal_c: cover property (op_select == adc_ctrl_pkg::OP_INT_ZERO && conv_done != 2'b00);
  force_c: cover property (force_full_scale != 2'b00);
endmodule // adc_ctrl_monitor
bind dual_adc_status_mode_ctrl adc_ctrl_monitor adc_ctrl_monitor_i (.core_clk, .arst_n,
  .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rdata, .conv_done, .ext_ref_selected,
  .primary_converter_on, .aux_converter_on, .op_select, .converters_reset,
  .result_write_allow, .force_full_scale);
`default_nettype wire

// >>> dv/testbench.sv
// Register-level testbench for the converter status and mode register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] MA = adc_ctrl_pkg::MODE_ADDR;
  localparam logic [7:0] SA = adc_ctrl_pkg::STAT_ADDR;
  logic       core_clk, arst_n, sfr_wr, sfr_bit_wdata, sfr_bit_wr, ref_fault_detect;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata;
  logic [1:0] conv_done, done_is_cal, result_saturated, cal_aborted, ext_ref_selected;
  logic       primary_converter_on, aux_converter_on, converters_reset;
  logic [2:0] op_select;
  logic [1:0] result_write_allow, force_full_scale;
  int         fails;
  int         samples_checked;
  dual_adc_status_mode_ctrl dual_adc_status_mode_ctrl_i (.core_clk, .arst_n, .sfr_addr,
    .sfr_wdata, .sfr_wr, .sfr_bit_addr, .sfr_bit_wdata, .sfr_bit_wr, .sfr_rdata,
    .conv_done, .done_is_cal, .result_saturated, .cal_aborted, .ext_ref_selected,
    .ref_fault_detect, .primary_converter_on, .aux_converter_on, .op_select,
    .converters_reset, .result_write_allow, .force_full_scale);
  // ************************************************
  // Bus and compare tasks, bus tasks entered at a falling edge
  // ************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic wb(input logic [7:0] a, input logic d);
    sfr_bit_addr = a;
    sfr_bit_wdata = d;
    sfr_bit_wr = 1'b1;
    @(negedge core_clk);
    sfr_bit_wr = 1'b0;
  endtask
  // Read data is registered, so the address leads the sample by one edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    @(negedge core_clk);
    check(sfr_rdata, exp);
  endtask
  task automatic dn(input logic [1:0] m, input logic [1:0] c, input logic [1:0] s,
                    input logic [1:0] b);
    conv_done = m;
    done_is_cal = c;
    result_saturated = s;
    cal_aborted = b;
    @(negedge core_clk);
    conv_done = 2'b00;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    {arst_n, sfr_wr, sfr_bit_wdata, sfr_bit_wr, ref_fault_detect} = 5'h00;
    {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
    {conv_done, done_is_cal, result_saturated, cal_aborted, ext_ref_selected} = 10'h000;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    rd(MA, 8'h00);
    rd(SA, 8'h00);
    check({6'h00, result_write_allow}, 8'h03);
    wr(8'hd2, 8'hff);
    rd(8'hd2, 8'h00);
    rd(MA, 8'h00);
    $display("test reset_values done");
    for (int m = 0; m < 8; m++)
    begin
      wr(MA, 8'hf8 | 8'(m));
      check({7'h00, converters_reset}, 8'h01);
      check({5'h00, op_select}, 8'(m));
      rd(MA, 8'h30 | 8'(m));
    end
    wr(MA, 8'hff);
    check({7'h00, converters_reset}, 8'h01);
    $display("test mode_codes done");
    // Idle edge so the strobe is not lowered and raised in one time step
    @(negedge core_clk);
    wr(MA, 8'h22);
    check({6'h00, aux_converter_on, primary_converter_on}, 8'h01);
    dn(2'b01, 2'b00, 2'b01, 2'b00);
    check({5'h00, op_select}, 8'h00);
    check({6'h00, result_write_allow}, 8'h02);
    rd(SA, 8'h88);
    wb(8'hdf, 1'b0);
    rd(SA, 8'h08);
    wb(8'hdd, 1'b1);
    @(negedge core_clk);
    wb(8'hdf, 1'b1);
    rd(SA, 8'h08);
    wr(SA, 8'hff);
    rd(SA, 8'h08);
    wr(MA, 8'h20);
    check({7'h00, converters_reset}, 8'h01);
    rd(SA, 8'h00);
    $display("test single_primary done");
    wr(MA, 8'h13);
    check({6'h00, aux_converter_on, primary_converter_on}, 8'h02);
    dn(2'b10, 2'b00, 2'b00, 2'b00);
    check({5'h00, op_select}, 8'h03);
    rd(SA, 8'h40);
    wb(8'hde, 1'b0);
    rd(SA, 8'h00);
    wr(MA, 8'h34);
    rd(SA, 8'h00);
    dn(2'b10, 2'b10, 2'b00, 2'b10);
    rd(SA, 8'h64);
    check({5'h00, op_select}, 8'h04);
    dn(2'b01, 2'b01, 2'b00, 2'b00);
    rd(SA, 8'he4);
    check({5'h00, op_select}, 8'h00);
    wr(SA, 8'h00);
    rd(SA, 8'h24);
    wr(MA, 8'h30);
    rd(SA, 8'h00);
    $display("test calibration done");
    ext_ref_selected = 2'b11;
    ref_fault_detect = 1'b1;
    repeat (2) @(negedge core_clk);
    rd(SA, 8'h00);
    check({6'h00, force_full_scale}, 8'h00);
    wr(MA, 8'h21);
    repeat (2) @(negedge core_clk);
    rd(SA, 8'h10);
    check({6'h00, force_full_scale}, 8'h03);
    ext_ref_selected = 2'b10;
    #1;
    check({6'h00, force_full_scale}, 8'h02);
    @(negedge core_clk);
    ref_fault_detect = 1'b0;
    repeat (2) @(negedge core_clk);
    rd(SA, 8'h00);
    $display("test reference done");
    wr(MA, 8'h23);
    dn(2'b01, 2'b00, 2'b00, 2'b00);
    rd(SA, 8'h80);
    // A clamped result arriving while ready is set is never written
    dn(2'b01, 2'b00, 2'b01, 2'b00);
    rd(SA, 8'h80);
    wb(8'hdf, 1'b0);
    dn(2'b01, 2'b00, 2'b01, 2'b00);
    rd(SA, 8'h88);
    $display("test saturation done");
    arst_n = 1'b0;
    @(negedge core_clk);
    arst_n = 1'b1;
    rd(MA, 8'h00);
    rd(SA, 8'h00);
    $display("test second_reset done");
    conclude();
  end
endmodule // testbench
`default_nettype wire

// >>> pkg/adc_ctrl_pkg.sv
// Shared constants for the dual converter status and mode control block
// Functional notes
// - Primary ready flag, status bit 7, sets when a primary conversion or calibration ends.
// - Primary ready clears on a software zero write or any mode register write.
// - While primary ready is set, primary results and coefficients are not written.
// - Auxiliary ready flag, status bit 6, behaves the same for the auxiliary converter.
// - Calibration done flag, status bit 5, sets when a calibration finishes.
// - Calibration done flag clears only through a mode register write.
// - Missing reference flag, status bit 4, updates only while a converter is active.
// - Missing reference flag follows the reference fault detector while evaluated.
// - Missing reference with external reference selected forces results to all ones.
// - Primary error flag, status bit 3, sets when a written result was saturated.
// - Primary error flag also sets when a calibration failed to update coefficients.
// - Primary error flag clears on a mode register write.
// - Auxiliary error flag, status bit 2, behaves the same for the auxiliary converter.
// - Mode bit 5 enables the primary converter; clear means power-down.
// - Mode bit 4 enables the auxiliary converter; clear means power-down.
// - Three mode bits: power-down, idle, single, continuous, four calibration kinds.
// - Every mode register write, even unchanged, resets both converters at once.
// - Single conversion finishes, updates flags, then mode field returns to power-down.
// - Calibration start clears ready flags; completion returns mode field to power-down.
package adc_ctrl_pkg;
  // ************************************************
  // Register addresses and reset values
  // ************************************************
  localparam logic [7:0] MODE_ADDR      = 8'hd1;
  localparam logic [7:0] STAT_ADDR      = 8'hd8;
  localparam logic [7:0] STAT_BIT_BASE  = 8'hd8;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] STAT_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;
  // ************************************************
  // Field positions
  // ************************************************
  localparam int STAT_PRI_READY = 7;
  localparam int STAT_AUX_READY = 6;
  localparam int STAT_CAL_DONE  = 5;
  localparam int STAT_REF_MISS  = 4;
  localparam int STAT_PRI_FAULT = 3;
  localparam int STAT_AUX_FAULT = 2;
  localparam int MODE_PRI_ON    = 5;
  localparam int MODE_AUX_ON    = 4;
  localparam int MODE_SEL_HI    = 2;
  localparam int MODE_SEL_LO    = 0;
  localparam logic [2:0] STAT_BIT_PRI_READY = 3'h7;
  localparam logic [2:0] STAT_BIT_AUX_READY = 3'h6;
  // ************************************************
  // Operating mode encodings
  // ************************************************
  localparam logic [2:0] OP_POWER_DOWN = 3'h0;
  localparam logic [2:0] OP_IDLE       = 3'h1;
  localparam logic [2:0] OP_SINGLE     = 3'h2;
  localparam logic [2:0] OP_CONTINUOUS = 3'h3;
  localparam logic [2:0] OP_INT_ZERO   = 3'h4;
  localparam logic [2:0] OP_INT_FULL   = 3'h5;
  localparam logic [2:0] OP_SYS_ZERO   = 3'h6;
  localparam logic [2:0] OP_SYS_FULL   = 3'h7;
  // ************************************************
  // Sequencer states
  // ************************************************
  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b001,
    SEQ_ONESHOT = 3'b010,
    SEQ_RUN     = 3'b100
  } seq_state_type;
endpackage

// >>> pkg/converter_if.sv
// Per-converter link between the register block and one flag tracker
`timescale 1ns/1ps
`default_nettype none
interface converter_if;
  logic done;
  logic cal_cycle;
  logic saturated;
  logic cal_failed;
  logic sw_clear_ready;
  logic start_clear;
  logic ready;
  logic fault;
  logic write_allow;
  logic cal_finished;
  modport ctrl (
    output done, cal_cycle, saturated, cal_failed, sw_clear_ready, start_clear,
    input  ready, fault, write_allow, cal_finished
  );
  modport chan (
    input  done, cal_cycle, saturated, cal_failed, sw_clear_ready, start_clear,
    output ready, fault, write_allow, cal_finished
  );
endinterface
`default_nettype wire

// >>> rtl/adc_channel_ctrl.sv
// Ready and fault flag tracker for one converter
`timescale 1ns/1ps
`default_nettype none
module adc_channel_ctrl (
  input wire logic   core_clk,
  input wire logic   arst_n,
  converter_if.chan  link
);
  logic ready_r;
  logic fault_r;
  logic fault_set;

  // Result inhibit while ready is still set
  assign link.write_allow = ~ready_r;
  assign link.ready = ready_r;
  assign link.fault = fault_r;
  assign link.cal_finished = link.done & link.cal_cycle;

  // Saturation counts only for a result that was really written
  assign fault_set = link.done &
                     ((~link.cal_cycle & ~ready_r & link.saturated) |
                      (link.cal_cycle & link.cal_failed));

  // ************************************************
  // Ready flag
  // ************************************************
  // set on completion
  // cleared by software or start
  // Set wins so a completion in the clear cycle is never lost
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ready_r <= 1'b0;
    else if (link.done)
      ready_r <= 1'b1;
    else if (link.sw_clear_ready | link.start_clear)
      ready_r <= 1'b0;
  end

  // ************************************************
  // Fault flag
  // ************************************************
  // saturation and calibration failure
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      fault_r <= 1'b0;
    else if (fault_set)
      fault_r <= 1'b1;
    else if (link.start_clear)
      fault_r <= 1'b0;
  end
endmodule // adc_channel_ctrl
`default_nettype wire

// >>> rtl/dual_adc_status_mode_ctrl.sv
// Status and mode registers for a primary and an auxiliary converter
`timescale 1ns/1ps
`default_nettype none
module dual_adc_status_mode_ctrl (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_bit_addr,
  input  wire logic        sfr_bit_wdata,
  input  wire logic        sfr_bit_wr,
  output logic      [7:0]  sfr_rdata,
  input  wire logic [1:0]  conv_done,
  input  wire logic [1:0]  done_is_cal,
  input  wire logic [1:0]  result_saturated,
  input  wire logic [1:0]  cal_aborted,
  input  wire logic [1:0]  ext_ref_selected,
  input  wire logic        ref_fault_detect,
  output logic             primary_converter_on,
  output logic             aux_converter_on,
  output logic      [2:0]  op_select,
  output logic             converters_reset,
  output logic      [1:0]  result_write_allow,
  output logic      [1:0]  force_full_scale
);
  // ************************************************
  // Register state
  // ************************************************
  logic                       pri_on_r;
  logic                       aux_on_r;
  logic [2:0]                 op_sel_r;
  logic                       cal_done_r;
  logic                       ref_miss_r;
  logic                       conv_reset_r;
  logic [1:0]                 pending_r;
  logic [1:0]                 pending_nxt;
  logic [7:0]                 rdata_r;
  logic [7:0]                 rdata_nxt;
  adc_ctrl_pkg::seq_state_type seq_r;
  adc_ctrl_pkg::seq_state_type seq_nxt;

  // ************************************************
  // Decoded accesses
  // ************************************************
  logic       mode_wr;
  logic       stat_wr;
  logic [1:0] sw_clear_ready;
  logic       bit_hit_pri;
  logic       bit_hit_aux;
  logic       wr_oneshot;
  logic       wr_running;
  logic       any_active;
  logic [2:0] wr_sel;
  logic [1:0] wr_on;
  logic [7:0] stat_value;
  logic [7:0] mode_value;
  logic [1:0] ready_flags;
  logic [1:0] fault_flags;
  logic [1:0] write_allow;
  logic [1:0] cal_finished;

  converter_if pri_link ();
  converter_if aux_link ();

  assign mode_wr = sfr_wr & (sfr_addr == adc_ctrl_pkg::MODE_ADDR);
  assign stat_wr = sfr_wr & (sfr_addr == adc_ctrl_pkg::STAT_ADDR);
  assign bit_hit_pri = sfr_bit_wr & ~sfr_bit_wdata &
                       (sfr_bit_addr == (adc_ctrl_pkg::STAT_BIT_BASE |
                                         {5'h00, adc_ctrl_pkg::STAT_BIT_PRI_READY}));
  assign bit_hit_aux = sfr_bit_wr & ~sfr_bit_wdata &
                       (sfr_bit_addr == (adc_ctrl_pkg::STAT_BIT_BASE |
                                         {5'h00, adc_ctrl_pkg::STAT_BIT_AUX_READY}));

  // zero write clears ready
  // Writing a one to a ready bit is ignored; only hardware sets it
  assign sw_clear_ready[0] = bit_hit_pri |
                             (stat_wr & ~sfr_wdata[adc_ctrl_pkg::STAT_PRI_READY]);
  assign sw_clear_ready[1] = bit_hit_aux |
                             (stat_wr & ~sfr_wdata[adc_ctrl_pkg::STAT_AUX_READY]);

  assign wr_sel = sfr_wdata[adc_ctrl_pkg::MODE_SEL_HI:adc_ctrl_pkg::MODE_SEL_LO];
  assign wr_on = {sfr_wdata[adc_ctrl_pkg::MODE_AUX_ON],
                  sfr_wdata[adc_ctrl_pkg::MODE_PRI_ON]};
  assign wr_oneshot = (wr_sel == adc_ctrl_pkg::OP_SINGLE) |
                      (wr_sel == adc_ctrl_pkg::OP_INT_ZERO) |
                      (wr_sel == adc_ctrl_pkg::OP_INT_FULL) |
                      (wr_sel == adc_ctrl_pkg::OP_SYS_ZERO) |
                      (wr_sel == adc_ctrl_pkg::OP_SYS_FULL);
  assign wr_running = (wr_sel == adc_ctrl_pkg::OP_CONTINUOUS);

  // active means enabled and out of power-down
  assign any_active = (pri_on_r | aux_on_r) &
                      (op_sel_r != adc_ctrl_pkg::OP_POWER_DOWN);

  // ************************************************
  // Converter flag trackers
  // ************************************************
  assign pri_link.done           = conv_done[0];
  assign pri_link.cal_cycle      = done_is_cal[0];
  assign pri_link.saturated      = result_saturated[0];
  assign pri_link.cal_failed     = cal_aborted[0];
  assign pri_link.sw_clear_ready = sw_clear_ready[0];
  assign pri_link.start_clear    = mode_wr;
  assign aux_link.done           = conv_done[1];
  assign aux_link.cal_cycle      = done_is_cal[1];
  assign aux_link.saturated      = result_saturated[1];
  assign aux_link.cal_failed     = cal_aborted[1];
  assign aux_link.sw_clear_ready = sw_clear_ready[1];
  assign aux_link.start_clear    = mode_wr;

  assign ready_flags  = {aux_link.ready, pri_link.ready};
  assign fault_flags  = {aux_link.fault, pri_link.fault};
  assign write_allow  = {aux_link.write_allow, pri_link.write_allow};
  assign cal_finished = {aux_link.cal_finished, pri_link.cal_finished};

  adc_channel_ctrl u_pri_chan (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .link     (pri_link)
  );

  adc_channel_ctrl u_aux_chan (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .link     (aux_link)
  );

  // ************************************************
  // Enable bits
  // ************************************************
  // primary and auxiliary enable
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pri_on_r <= adc_ctrl_pkg::MODE_RESET[adc_ctrl_pkg::MODE_PRI_ON];
      aux_on_r <= adc_ctrl_pkg::MODE_RESET[adc_ctrl_pkg::MODE_AUX_ON];
    end
    else if (mode_wr)
    begin
      pri_on_r <= wr_on[0];
      aux_on_r <= wr_on[1];
    end
  end

  // ************************************************
  // One-shot sequencer
  // ************************************************
  // Tracks which enabled converters still owe a completion
  always_comb
  begin
    seq_nxt = seq_r;
    pending_nxt = pending_r;
    if (mode_wr)
    begin
      pending_nxt = 2'h0;
      if (wr_oneshot && (wr_on != 2'h0))
      begin
        seq_nxt = adc_ctrl_pkg::SEQ_ONESHOT;
        pending_nxt = wr_on;
      end
      else if (wr_running && (wr_on != 2'h0))
        seq_nxt = adc_ctrl_pkg::SEQ_RUN;
      else
        seq_nxt = adc_ctrl_pkg::SEQ_IDLE;
    end
    else
    begin
      case (seq_r)
        adc_ctrl_pkg::SEQ_ONESHOT:
        begin
          pending_nxt = pending_r & ~conv_done;
          if (pending_nxt == 2'h0)
            seq_nxt = adc_ctrl_pkg::SEQ_IDLE;
        end
        adc_ctrl_pkg::SEQ_RUN:
          seq_nxt = adc_ctrl_pkg::SEQ_RUN;
        default:
          seq_nxt = adc_ctrl_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_r <= adc_ctrl_pkg::SEQ_IDLE;
      pending_r <= 2'h0;
    end
    else
    begin
      seq_r <= seq_nxt;
      pending_r <= pending_nxt;
    end
  end

  // ************************************************
  // Mode field
  // ************************************************
  // A software write in the completion cycle wins over the return
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      op_sel_r <= adc_ctrl_pkg::MODE_RESET[adc_ctrl_pkg::MODE_SEL_HI:adc_ctrl_pkg::MODE_SEL_LO];
    else if (mode_wr)
      op_sel_r <= wr_sel;
    else if ((seq_r == adc_ctrl_pkg::SEQ_ONESHOT) && (pending_nxt == 2'h0))
      op_sel_r <= adc_ctrl_pkg::OP_POWER_DOWN;
  end

  // reset both on any mode write
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      conv_reset_r <= 1'b0;
    else
      conv_reset_r <= mode_wr;
  end

  // ************************************************
  // Shared status flags
  // ************************************************
  // calibration done set
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cal_done_r <= adc_ctrl_pkg::STAT_RESET[adc_ctrl_pkg::STAT_CAL_DONE];
    else if (cal_finished != 2'h0)
      cal_done_r <= 1'b1;
    else if (mode_wr)
      cal_done_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ref_miss_r <= adc_ctrl_pkg::STAT_RESET[adc_ctrl_pkg::STAT_REF_MISS];
    else if (any_active)
      ref_miss_r <= ref_fault_detect;
  end

  // ************************************************
  // Register read
  // ************************************************
  // reserved bits read zero
  always_comb
  begin
    stat_value = 8'h00;
    stat_value[adc_ctrl_pkg::STAT_PRI_READY] = ready_flags[0];
    stat_value[adc_ctrl_pkg::STAT_AUX_READY] = ready_flags[1];
    stat_value[adc_ctrl_pkg::STAT_CAL_DONE]  = cal_done_r;
    stat_value[adc_ctrl_pkg::STAT_REF_MISS]  = ref_miss_r;
    stat_value[adc_ctrl_pkg::STAT_PRI_FAULT] = fault_flags[0];
    stat_value[adc_ctrl_pkg::STAT_AUX_FAULT] = fault_flags[1];
    mode_value = 8'h00;
    mode_value[adc_ctrl_pkg::MODE_PRI_ON] = pri_on_r;
    mode_value[adc_ctrl_pkg::MODE_AUX_ON] = aux_on_r;
    mode_value[adc_ctrl_pkg::MODE_SEL_HI:adc_ctrl_pkg::MODE_SEL_LO] = op_sel_r;
  end

  always_comb
  begin
    if (sfr_addr == adc_ctrl_pkg::STAT_ADDR)
      rdata_nxt = stat_value;
    else if (sfr_addr == adc_ctrl_pkg::MODE_ADDR)
      rdata_nxt = mode_value;
    else
      rdata_nxt = adc_ctrl_pkg::UNMAPPED_READ;
  end

  // Registered read costs one cycle but keeps the data output glitch free
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  // ************************************************
  // Converter side outputs
  // ************************************************
  assign sfr_rdata            = rdata_r;
  assign primary_converter_on = pri_on_r;
  assign aux_converter_on     = aux_on_r;
  assign op_select            = op_sel_r;
  assign converters_reset     = conv_reset_r;
  // same inhibit for the auxiliary side
  assign result_write_allow   = write_allow;
  // clamp to all ones on missing reference with external reference selected
  assign force_full_scale     = {2{ref_miss_r}} & ext_ref_selected;
endmodule // dual_adc_status_mode_ctrl
`default_nettype wire
